// *** ptir_pkg.sv ***
/*
 * Shared constants and types for the pressure and temperature readout
 * target: register indices, reset values, bus framing, calibration
 * codes and the state encoding of the serial target.
 * Assumes a single 100 MHz clock domain and 8-bit register indices.
 */
`default_nettype none

package ptir_pkg;

  localparam logic [7:0] IDX_ID        = 8'h00;
  localparam logic [7:0] IDX_LAUNCH    = 8'h01;
  localparam logic [7:0] IDX_P_HIGH    = 8'h04;
  localparam logic [7:0] IDX_P_MID     = 8'h05;
  localparam logic [7:0] IDX_P_LOW     = 8'h06;
  localparam logic [7:0] IDX_T_HIGH    = 8'h07;
  localparam logic [7:0] IDX_T_LOW     = 8'h08;
  localparam logic [7:0] IDX_CAL_OFF   = 8'h20;
  localparam logic [7:0] IDX_CAL_SHIFT = 8'h21;

  localparam logic [7:0] LAUNCH_CMD     = 8'h01;
  localparam logic [7:0] LAUNCH_RESET   = 8'h37;
  localparam logic [7:0] RESULT_RESET   = 8'h00;
  localparam logic [7:0] UNMAPPED_VALUE = 8'h00;
  localparam logic [7:0] PTR_STEP       = 8'h01;

  // Arbitrary identification value.
  localparam logic [7:0] ID_VALUE    = 8'hA5;
  // Arbitrary 7-bit bus address of this target.
  localparam logic [6:0] TARGET_ADDR = 7'h2A;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_STEP  = 4'h1;
  localparam logic [2:0] SYNC_IDLE = 3'h7;

  localparam int         CAL_SIGN_BIT = 7;
  localparam logic [6:0] CAL_MAG_4096  = 7'h0C;
  localparam logic [6:0] CAL_MAG_8192  = 7'h0D;
  localparam logic [6:0] CAL_MAG_16384 = 7'h0E;
  localparam logic [7:0] CAL_OFFSET_DEFAULT = 8'h0D;
  // Shift codes are ten times the exponent: 7, 6 and 5.5.
  localparam logic [7:0] CAL_SHIFT_70 = 8'h46;
  localparam logic [7:0] CAL_SHIFT_60 = 8'h3C;
  localparam logic [7:0] CAL_SHIFT_55 = 8'h37;
  localparam logic [7:0] CAL_SHIFT_DEFAULT = 8'h3C;

  typedef struct packed {
    logic [23:0] pressure;
    logic [15:0] temperature;
  } ptir_sample_t;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ACK_WR   = 4'h2,
    ST_INDEX    = 4'h3,
    ST_DATA_ACK = 4'h4,
    ST_WRITE    = 4'h5,
    ST_ACK_RD   = 4'h6,
    ST_READ     = 4'h7,
    ST_READ_ACK = 4'h8
  } ptir_state_t;

  function automatic logic cal_offset_legal(input logic [7:0] code);
    logic [6:0] mag;
    mag = code[6:0];
    cal_offset_legal = (mag == CAL_MAG_4096) || (mag == CAL_MAG_8192) ||
                       (mag == CAL_MAG_16384);
  endfunction

  function automatic logic cal_shift_legal(input logic [7:0] code);
    cal_shift_legal = (code == CAL_SHIFT_70) || (code == CAL_SHIFT_60) ||
                      (code == CAL_SHIFT_55);
  endfunction

endpackage

`default_nettype wire

// *** ptir_pin_sync.sv ***
/*
 * Two-flop synchroniser for one bus pin with edge detection behind it.
 * Assumes the pin idles high, as a pulled-up open-drain line does.
 */
`default_nettype none

module ptir_pin_sync
  import ptir_pkg::*;
(
  input  wire logic clock,
  input  wire logic nrst,
  input  wire logic pin,
  output wire logic level,
  output wire logic rise,
  output wire logic fall
);

  logic [2:0] stage_reg;
  logic [2:0] stage_next;

  always_comb begin
    stage_next = {stage_reg[1:0], pin};
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stage_reg <= SYNC_IDLE;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // Edges are taken past the second flop so a metastable first stage
  // never reaches the detectors.
  assign level = stage_reg[1];
  assign rise  = stage_reg[1] & ~stage_reg[2];
  assign fall  = ~stage_reg[1] & stage_reg[2];

endmodule

`default_nettype wire

// *** ptir_readout.sv ***
/*
 * Two-wire serial target of a pressure and temperature readout: register
 * pointer, launch register, result registers refreshed by the converter,
 * calibration bytes and a coherent snapshot for read bursts.
 * Assumes scl_in and sda_in are the bus wires, pulled up outside, and
 * that sample arrives with sample_valid from logic on the same clock.
 */
`default_nettype none

module ptir_readout
  import ptir_pkg::*;
#(
  parameter logic [7:0] CAL_OFFSET_CODE = CAL_OFFSET_DEFAULT,
  parameter logic [7:0] CAL_SHIFT_CODE  = CAL_SHIFT_DEFAULT
)(
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         scl_in,
  input  wire logic         sda_in,
  output var  logic         sda_out,
  output var  logic         sda_oe,
  input  wire ptir_sample_t sample,
  input  wire logic         sample_valid,
  output var  logic         conv_start
);

  localparam logic [7:0] CAL_OFFSET_USED =
    cal_offset_legal(CAL_OFFSET_CODE) ? CAL_OFFSET_CODE : CAL_OFFSET_DEFAULT;
  localparam logic [7:0] CAL_SHIFT_USED =
    cal_shift_legal(CAL_SHIFT_CODE) ? CAL_SHIFT_CODE : CAL_SHIFT_DEFAULT;

  logic [1:0]   pin_raw;
  logic [1:0]   pin_lvl;
  logic [1:0]   pin_rise;
  logic [1:0]   pin_fall;
  logic         scl_rise;
  logic         scl_fall;
  logic         sda_lvl;
  logic         start_det;
  logic         stop_det;

  ptir_state_t  state_reg;
  ptir_state_t  state_next;
  logic [3:0]   bit_cnt_reg;
  logic [3:0]   bit_cnt_next;
  logic [7:0]   shift_reg;
  logic [7:0]   shift_next;
  logic [7:0]   ptr_reg;
  logic [7:0]   ptr_next;
  logic [7:0]   launch_reg;
  logic [7:0]   launch_next;
  logic         oe_reg;
  logic         oe_next;
  logic         start_reg;
  logic         start_next;
  logic         sda_out_reg;
  ptir_sample_t res_reg;
  ptir_sample_t res_next;
  ptir_sample_t snap_reg;
  ptir_sample_t snap_next;
  logic         wr_fire;
  logic         load_byte;

  assign pin_raw = {sda_in, scl_in};

  generate
    for (genvar g = 0; g < 2; g++) begin : g_sync
      ptir_pin_sync u_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   (pin_raw[g]),
        .level (pin_lvl[g]),
        .rise  (pin_rise[g]),
        .fall  (pin_fall[g])
      );
    end
  endgenerate

  assign scl_rise  = pin_rise[0];
  assign scl_fall  = pin_fall[0];
  assign sda_lvl   = pin_lvl[1];
  assign start_det = pin_lvl[0] & pin_fall[1];
  assign stop_det  = pin_lvl[0] & pin_rise[1];

  function automatic logic [7:0] rd_byte(input logic [7:0]   idx,
                                         input ptir_sample_t s,
                                         input logic [7:0]   launch);
    case (idx)
      IDX_ID:        rd_byte = ID_VALUE;
      IDX_LAUNCH:    rd_byte = launch;
      IDX_P_HIGH:    rd_byte = s.pressure[23:16];
      IDX_P_MID:     rd_byte = s.pressure[15:8];
      IDX_P_LOW:     rd_byte = s.pressure[7:0];
      IDX_T_HIGH:    rd_byte = s.temperature[15:8];
      IDX_T_LOW:     rd_byte = s.temperature[7:0];
      IDX_CAL_OFF:   rd_byte = CAL_OFFSET_USED;
      IDX_CAL_SHIFT: rd_byte = CAL_SHIFT_USED;
      default:       rd_byte = UNMAPPED_VALUE;
    endcase
  endfunction

  // Bus target: bits are sampled on SCL rise and driven after SCL fall.
  always_comb begin
    logic [7:0] tx;
    tx           = rd_byte(ptr_reg, snap_reg, launch_reg);
    state_next   = state_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    ptr_next     = ptr_reg;
    launch_next  = launch_reg;
    oe_next      = oe_reg;
    snap_next    = snap_reg;
    start_next   = 1'b0;
    wr_fire      = 1'b0;
    load_byte    = 1'b0;
    if (stop_det) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else if (start_det) begin
      state_next   = ST_ADDR;
      bit_cnt_next = 4'h0;
      oe_next      = 1'b0;
    end else if (scl_rise) begin
      if (state_reg inside {ST_ADDR, ST_INDEX, ST_WRITE}) begin
        shift_next   = {shift_reg[6:0], sda_lvl};
        bit_cnt_next = bit_cnt_reg + BIT_STEP;
      end else if (state_reg == ST_READ) begin
        bit_cnt_next = bit_cnt_reg + BIT_STEP;
      end else if (state_reg == ST_READ_ACK && sda_lvl) begin
        // A not-acknowledge ends the burst; wait for stop or start.
        state_next = ST_IDLE;
      end
    end else if (scl_fall) begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            if (shift_reg[7:1] == TARGET_ADDR) begin
              oe_next = 1'b1;
              if (shift_reg[0]) begin
                snap_next  = res_reg;
                state_next = ST_ACK_RD;
              end else begin
                state_next = ST_ACK_WR;
              end
            end else begin
              state_next = ST_IDLE;
            end
          end
        end
        ST_ACK_WR, ST_DATA_ACK: begin
          oe_next      = 1'b0;
          bit_cnt_next = 4'h0;
          state_next   = (state_reg == ST_ACK_WR) ? ST_INDEX : ST_WRITE;
        end
        ST_INDEX: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            ptr_next   = shift_reg;
            oe_next    = 1'b1;
            state_next = ST_DATA_ACK;
          end
        end
        ST_WRITE: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            wr_fire    = 1'b1;
            ptr_next   = ptr_reg + PTR_STEP;
            oe_next    = 1'b1;
            state_next = ST_DATA_ACK;
            if (ptr_reg == IDX_LAUNCH) begin
              launch_next = shift_reg;
              start_next  = (shift_reg == LAUNCH_CMD);
            end
          end
        end
        ST_ACK_RD, ST_READ_ACK: begin
          load_byte    = 1'b1;
          shift_next   = tx;
          oe_next      = ~tx[7];
          bit_cnt_next = 4'h0;
          state_next   = ST_READ;
        end
        ST_READ: begin
          if (bit_cnt_reg == BYTE_BITS) begin
            oe_next    = 1'b0;
            ptr_next   = ptr_reg + PTR_STEP;
            state_next = ST_READ_ACK;
          end else begin
            oe_next    = ~shift_reg[6];
            shift_next = {shift_reg[6:0], 1'b0};
          end
        end
        default: begin
          state_next = ST_IDLE;
          oe_next    = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg   <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      ptr_reg     <= 8'h00;
      launch_reg  <= LAUNCH_RESET;
      oe_reg      <= 1'b0;
      start_reg   <= 1'b0;
      snap_reg    <= '0;
      sda_out_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      ptr_reg     <= ptr_next;
      launch_reg  <= launch_next;
      oe_reg      <= oe_next;
      start_reg   <= start_next;
      snap_reg    <= snap_next;
      sda_out_reg <= 1'b0;
    end
  end

  // Results move on every new sample; a burst reads the snapshot, so a
  // sample landing mid-burst never tears pressure from temperature.
  always_comb begin
    res_next = sample_valid ? sample : res_reg;
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      res_reg <= {RESULT_RESET, RESULT_RESET, RESULT_RESET,
                  RESULT_RESET, RESULT_RESET};
    end else begin
      res_reg <= res_next;
    end
  end

  // The line is open drain: only a low level is ever driven.
  assign sda_out    = sda_out_reg;
  assign sda_oe     = oe_reg;
  assign conv_start = start_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  sequence s_addr_match;
    state_reg == ST_ADDR && scl_fall && !start_det && !stop_det &&
    bit_cnt_reg == BYTE_BITS && shift_reg[7:1] == TARGET_ADDR;
  endsequence
  sequence s_launch_write;
    wr_fire && ptr_reg == IDX_LAUNCH && shift_reg == LAUNCH_CMD;
  endsequence
  sequence s_one_pulse;
    conv_start ##1 !conv_start;
  endsequence

  a_addr_ack_drive: assert property (
    s_addr_match |=> sda_oe && state_reg inside {ST_ACK_WR, ST_ACK_RD})
    else $error("address match not acknowledged");
  a_launch_pulse: assert property (
    s_launch_write |=> s_one_pulse ##0 launch_reg == LAUNCH_CMD)
    else $error("launch write gave no single start pulse");
  a_start_cause: assert property (
    $rose(conv_start) |-> $past(wr_fire) && $past(ptr_reg) == IDX_LAUNCH)
    else $error("start pulse without launch write");
  a_results_fresh: assert property (
    sample_valid |=> res_reg == $past(sample))
    else $error("result registers missed a sample");

  a_burst_snapshot: assert property (
    s_addr_match ##0 shift_reg[0] |=> snap_reg == $past(res_reg))
    else $error("read burst snapshot not taken");
  a_ptr_advance: assert property (
    state_reg == ST_READ_ACK && $past(state_reg) == ST_READ |->
      ptr_reg == $past(ptr_reg) + PTR_STEP)
    else $error("pointer did not advance after a byte");

  a_press_high: assert property (
    load_byte && ptr_reg == IDX_P_HIGH |=>
      shift_reg == snap_reg.pressure[23:16] && sda_oe == ~shift_reg[7])
    else $error("pressure high byte wrong");

  a_temp_low: assert property (
    load_byte && ptr_reg == IDX_T_LOW |=>
      shift_reg == snap_reg.temperature[7:0])
    else $error("temperature low byte wrong");
  a_offset_sign: assert property (
    load_byte && ptr_reg == IDX_CAL_OFF |=>
      shift_reg[CAL_SIGN_BIT] == CAL_OFFSET_USED[CAL_SIGN_BIT] &&
      shift_reg == CAL_OFFSET_USED)
    else $error("calibration offset byte wrong");

  a_offset_legal: assert property (
    load_byte && ptr_reg == IDX_CAL_OFF |=>
      cal_offset_legal(shift_reg) && sda_oe == ~shift_reg[7])
    else $error("calibration offset magnitude illegal");
  a_shift_legal: assert property (
    load_byte && ptr_reg == IDX_CAL_SHIFT |=>
      cal_shift_legal(shift_reg) && sda_oe == ~shift_reg[7])
    else $error("calibration shift code illegal");

  a_ack_release: assert property (
    state_reg == ST_DATA_ACK && scl_fall && !start_det && !stop_det |=>
      !sda_oe && state_reg == ST_WRITE)
    else $error("acknowledge not released");

endmodule

`default_nettype wire

// *** ptir_host_model.sv ***
/*
 * Host controller model for the two-wire readout target: start, stop,
 * byte transfers and register write and read bursts.
 * Assumes the bench resolves the open-drain data wire and feeds it back.
 */
`default_nettype none

module ptir_host_model
  import ptir_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       sda_wire,
  output var  logic       scl,
  output var  logic       sda_drv,
  output var  logic [7:0] rx_byte,
  output var  logic       rx_stb
);
  timeunit 1ns;
  timeprecision 100ps;

  // A quarter bit of ten clocks keeps the low phase at 200 ns.
  localparam int QTR = 10;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
    rx_byte = 8'h00;
    rx_stb = 1'b0;
  end

  task automatic wait_q(input int n);
    repeat (n * QTR) @(negedge clock);
  endtask

  task automatic start_cond();
    sda_drv = 1'b1;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    sda_drv = 1'b0;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask

  task automatic stop_cond();
    sda_drv = 1'b0;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    sda_drv = 1'b1;
    wait_q(2);
  endtask

  task automatic put_bit(input logic b);
    sda_drv = b;
    wait_q(1);
    scl = 1'b1;
    wait_q(2);
    scl = 1'b0;
    wait_q(1);
  endtask

  task automatic get_bit(output logic b);
    sda_drv = 1'b1;
    wait_q(1);
    scl = 1'b1;
    wait_q(1);
    b = sda_wire;
    wait_q(1);
    scl = 1'b0;
    wait_q(1);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic nack);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(nack);
  endtask

  task automatic recv_byte(input logic last);
    logic [7:0] b;
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    rx_byte = b;
    rx_stb = 1'b1;
    @(negedge clock);
    rx_stb = 1'b0;
    put_bit(last);
  endtask

  // Signed pressure code scaled to pascals for a given span.
  function automatic int press_pa(input logic [23:0] raw, input int span);
    int s;
    s = (raw >= 24'h800000) ? int'(raw) - 16777216 : int'(raw);
    press_pa = int'(real'(s) / 2097152.0 * real'(span) * 1000.0);
  endfunction

  // Raw temperature to a signed code; 0x8000 itself stays positive.
  function automatic int temp_signed(input logic [15:0] raw);
    temp_signed = (raw > 16'h8000) ? int'(raw) - 65536 : int'(raw);
  endfunction

  // Celsius from the raw code and the calibration pair.
  function automatic real celsius(input logic [15:0] raw,
                                  input logic [7:0]  off,
                                  input logic [7:0]  shf);
    int temperature_offset;
    temperature_offset = 4096 << (int'(off[6:0]) - 12);
    if (off[7]) begin
      temperature_offset = -temperature_offset;
    end
    celsius = real'(temp_signed(raw) - temperature_offset) /
              (2.0 ** (real'(shf) / 10.0)) + 25.0;
  endfunction

  task automatic write_reg(input logic [6:0] addr, input logic [7:0] idx,
                           input logic [7:0] val, output logic nack);
    logic a0, a1, a2;
    start_cond();
    send_byte({addr, 1'b0}, a0);
    send_byte(idx, a1);
    send_byte(val, a2);
    stop_cond();
    nack = a0 | a1 | a2;
  endtask

  task automatic read_burst(input logic [7:0] idx, input int n,
                            output logic nack);
    logic a0, a1, a2;
    start_cond();
    send_byte({TARGET_ADDR, 1'b0}, a0);
    send_byte(idx, a1);
    start_cond();
    send_byte({TARGET_ADDR, 1'b1}, a2);
    for (int k = 0; k < n; k++) begin
      recv_byte(k == n - 1);
    end
    stop_cond();
    nack = a0 | a1 | a2;
  endtask
endmodule

`default_nettype wire

// *** tb.sv ***
/*
 * Self-checking bench of the readout target: reset values, launch,
 * result bursts with refresh during a burst, calibration bytes.
 * Assumes the host model drives the bus and pull-ups idle it high.
 */
`default_nettype none

module tb;
  import ptir_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [7:0] OFF_CODE   = 8'h8E;
  localparam logic [7:0] SHIFT_CODE = 8'h37;
  // Rated span of the modelled part; any span suits the check.
  localparam int         SPAN_KPA    = 100;
  localparam int         LAUNCH_WAIT = 200;

  logic         clock, nrst, scl, sda_drv, sda_out, sda_oe;
  logic         sample_valid, conv_start, rx_stb;
  logic [7:0]   rx_byte;
  logic [7:0]   exp_q[$];
  logic [31:0]  lfsr;
  logic [39:0]  rx_hist;
  ptir_sample_t sample;
  wire logic    sda_wire;
  int           err_count, checked, conv_count;

  assign sda_wire = (sda_oe ? sda_out : 1'b1) & sda_drv;

  ptir_readout #(
    .CAL_OFFSET_CODE(OFF_CODE),
    .CAL_SHIFT_CODE (SHIFT_CODE)
  ) ptir_readout_inst (
    .clock(clock), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire),
    .sda_out(sda_out), .sda_oe(sda_oe), .sample(sample),
    .sample_valid(sample_valid), .conv_start(conv_start)
  );

  ptir_host_model ptir_host_model_inst (
    .clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_drv(sda_drv),
    .rx_byte(rx_byte), .rx_stb(rx_stb)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] idx, input int n);
    logic a;
    ptir_host_model_inst.read_burst(idx, n, a);
    check({7'h00, a}, 8'h00);
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] idx,
                    input logic [7:0] val, input logic nack);
    logic a;
    ptir_host_model_inst.write_reg(addr, idx, val, a);
    check({7'h00, a}, {7'h00, nack});
  endtask

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    lfsr_step = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic new_sample();
    lfsr = lfsr_step(lfsr);
    sample = {lfsr, lfsr[15:8]};
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
  endtask

  // Pressure then temperature, high byte first.
  task automatic expect_sample(input ptir_sample_t s);
    exp_q.push_back(s.pressure[23:16]);
    exp_q.push_back(s.pressure[15:8]);
    exp_q.push_back(s.pressure[7:0]);
    exp_q.push_back(s.temperature[15:8]);
    exp_q.push_back(s.temperature[7:0]);
  endtask

  always @(posedge clock) begin
    if (rx_stb === 1'b1) begin
      check(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
      rx_hist <= {rx_hist[31:0], rx_byte};
    end
    if (conv_start === 1'b1) begin
      conv_count++;
    end
  end

  initial begin
    int c0;
    int pa;
    int degc;
    nrst = 1'b0;
    sample = '0;
    sample_valid = 1'b0;
    lfsr = 32'h00015EE0;
    repeat (12) @(negedge clock);
    nrst = 1'b1;
    repeat (4) @(negedge clock);
    exp_q.push_back(ID_VALUE);
    exp_q.push_back(LAUNCH_RESET);
    rd(IDX_ID, 2);
    expect_sample('0);
    rd(IDX_P_HIGH, 5);
    c0 = conv_count;
    wr(TARGET_ADDR, IDX_LAUNCH, LAUNCH_CMD, 1'b0);
    check(8'(conv_count - c0), 8'h01);
    // Hold off after launch. Nothing in the bench answers conv_start,
    // so a short wait stands in for the full conversion time.
    repeat (LAUNCH_WAIT) @(negedge clock);
    exp_q.push_back(LAUNCH_CMD);
    rd(IDX_LAUNCH, 1);
    // Any other value is stored but must not start a conversion.
    wr(TARGET_ADDR, IDX_LAUNCH, 8'h02, 1'b0);
    wr(TARGET_ADDR ^ 7'h01, IDX_LAUNCH, LAUNCH_CMD, 1'b1);
    check(8'(conv_count - c0), 8'h01);
    exp_q.push_back(8'h02);
    rd(IDX_LAUNCH, 1);
    // A refresh mid-burst must not tear the bytes already promised.
    for (int k = 0; k < 3; k++) begin
      new_sample();
      expect_sample(sample);
      fork
        rd(IDX_P_HIGH, 5);
        begin
          repeat (2000) @(negedge clock);
          new_sample();
        end
      join
    end
    expect_sample(sample);
    rd(IDX_P_HIGH, 5);
    wr(TARGET_ADDR, IDX_P_HIGH, 8'hFF, 1'b0);
    exp_q.push_back(sample.pressure[23:16]);
    exp_q.push_back(UNMAPPED_VALUE);
    rd(IDX_P_HIGH, 1);
    rd(8'h10, 1);
    // Codes chosen so the host arithmetic lands on known values.
    sample = {24'hE00000, 16'hC000};
    sample_valid = 1'b1;
    @(negedge clock);
    sample_valid = 1'b0;
    expect_sample(sample);
    rd(IDX_P_HIGH, 5);
    pa = ptir_host_model_inst.press_pa(rx_hist[39:16], SPAN_KPA);
    check(8'(pa / 1000 + SPAN_KPA), 8'h00);
    exp_q.push_back(OFF_CODE);
    exp_q.push_back(SHIFT_CODE);
    rd(IDX_CAL_OFF, 2);
    degc = int'(ptir_host_model_inst.celsius(rx_hist[31:16],
                                             rx_hist[15:8],
                                             rx_hist[7:0]));
    check(8'(degc), 8'h19);
    check(8'(exp_q.size()), 8'h00);
    report_and_stop();
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    $display("BAD %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule

`default_nettype wire
